/* File: logic/hpc_cnt_slice.sv */
`timescale 1ns/1ps
`default_nettype none

module hpc_cnt_slice
	import hpc_pkg::*;
#(
	parameter int W    = 64,
	parameter bit IMPL = 1'b1
) (
	hpc_slice_if.slice bus
);
	// bits above W are legalised to zero
	localparam logic [CNT_W-1:0] WMASK = (W >= CNT_W) ? '1 : ((CNT_ONE << W) - CNT_ONE);

	always_comb begin
		bus.nxt = bus.cur;
		if (!IMPL) begin
			bus.nxt = '0;
		end else begin
			if (bus.we_lo) begin
				bus.nxt[XLEN-1:0] = bus.wdata;
			end
			if (bus.we_hi) begin
				bus.nxt[CNT_W-1:XLEN] = bus.wdata;
			end
			// a write beats the increment of the same cycle
			if (!bus.we_lo && !bus.we_hi && bus.inc && !bus.inh) begin
				bus.nxt = bus.cur + CNT_ONE;
			end
			bus.nxt = bus.nxt & WMASK;
		end
	end

endmodule : hpc_cnt_slice

`default_nettype wire

/* File: logic/hpc_csr_dec.sv */
`timescale 1ns/1ps
`default_nettype none

module hpc_csr_dec
	import hpc_pkg::*;
#(
	parameter bit HAS_UMODE = 1'b1,
	parameter bit HAS_SMODE = 1'b1,
	parameter bit HAS_OVF   = 1'b0
) (
	hpc_dec_if.dec bus
);
	logic [2:0] view;
	logic [4:0] idx;
	logic       not_m;

	function automatic logic lower_read_ok(input logic [1:0] priv, input logic [XLEN-1:0] mask,
			input logic [4:0] i);
		logic [1:0] next_mode;
		next_mode = HAS_SMODE ? PRIV_S : PRIV_U;
		return (priv == PRIV_M) || (HAS_UMODE && (priv == next_mode) && mask[i]);
	endfunction : lower_read_ok

	always_comb begin
		view = bus.addr[CSR_AW-1:VIEW_LSB];
		idx = bus.addr[VIEW_LSB-1:0];
		not_m = (bus.priv != PRIV_M);
		unique case (view)
			VIEW_M_LO, VIEW_M_HI: begin
				bus.illegal = not_m || (idx == IDX_TIME);
			end
			VIEW_SEL_LO: begin
				bus.illegal = not_m || (idx < IDX_FIRST_EVT);
			end
			VIEW_SEL_HI: begin
				bus.illegal = not_m || (idx < IDX_FIRST_EVT) || !HAS_OVF;
			end
			VIEW_U_LO, VIEW_U_HI: begin
				// mirrors take no writes
				bus.illegal = bus.we || !lower_read_ok(bus.priv, bus.mask, idx);
			end
			VIEW_CTRL: begin
				bus.illegal = not_m || !((idx == IDX_CTRL_MASK && HAS_UMODE) || idx == IDX_CTRL_INH);
			end
			default: begin
				bus.illegal = 1'b1;
			end
		endcase
		bus.view = view;
		bus.idx = idx;
	end

endmodule : hpc_csr_dec

`default_nettype wire

/* File: logic/hpc_if.sv */
`timescale 1ns/1ps
`default_nettype none

interface hpc_slice_if;
	import hpc_pkg::*;
	logic [CNT_W-1:0] cur;
	logic [CNT_W-1:0] nxt;
	logic             inc;
	logic             inh;
	logic             we_lo;
	logic             we_hi;
	logic [XLEN-1:0]  wdata;
	modport owner (output cur, inc, inh, we_lo, we_hi, wdata, input nxt);
	modport slice (input cur, inc, inh, we_lo, we_hi, wdata, output nxt);
endinterface : hpc_slice_if

interface hpc_dec_if;
	import hpc_pkg::*;
	logic [CSR_AW-1:0] addr;
	logic [1:0]        priv;
	logic [XLEN-1:0]   mask;
	logic              we;
	logic [2:0]        view;
	logic [4:0]        idx;
	logic              illegal;
	modport host (output addr, priv, mask, we, input view, idx, illegal);
	modport dec (input addr, priv, mask, we, output view, idx, illegal);
endinterface : hpc_dec_if

`default_nettype wire

/* File: logic/hpc_perf_counter_unit.sv */
`timescale 1ns/1ps
`default_nettype none

module hpc_perf_counter_unit
	import hpc_pkg::*;
#(
	parameter int          CTR_WIDTH    = 64,
	parameter int          SEL_WIDTH    = 8,
	parameter int          NUM_EVT_IN   = 16,
	parameter logic [31:0] EVT_IMPL     = 32'hffff_fff8,
	parameter bit          HAS_UMODE    = 1'b1,
	parameter bit          HAS_SMODE    = 1'b1,
	parameter bit          HAS_OVF      = 1'b0,
	parameter bit          CYCLE_SHARED = 1'b0
) (
	input  wire logic                  clock_i,
	input  wire logic                  sys_rst_i,
	input  wire logic                  csr_req_i,
	input  wire logic                  csr_we_i,
	input  wire logic [CSR_AW-1:0]     csr_addr_i,
	input  wire logic [XLEN-1:0]       csr_wdata_i,
	input  wire logic [1:0]            csr_priv_i,
	input  wire logic                  retire_i,
	input  wire logic [NUM_EVT_IN-1:0] event_i,
	input  wire logic [CNT_W-1:0]      wallclock_i,
	input  wire logic [SHARE_W-1:0]    peer_share_we_i,
	input  wire logic [XLEN-1:0]       peer_share_wdata_i,
	output logic                       csr_ack_o,
	output logic [XLEN-1:0]            csr_rdata_o,
	output logic                       csr_illegal_o,
	output logic [SHARE_W-1:0]         share_we_o,
	output logic [XLEN-1:0]            share_wdata_o
);
	localparam logic [CNT_W-1:0] SEL_MASK =
		(SEL_WIDTH >= CNT_W) ? '1 : ((CNT_ONE << SEL_WIDTH) - CNT_ONE);
	localparam logic [XLEN-1:0] INH_LEGAL = (EVT_IMPL | CORE_CTR_BITS) & ~TIME_BIT;

	hpc_state_t       st;
	hpc_state_t       next_st;
	logic             wr_ok;
	logic [CNT_W-1:0] slice_nxt [NUM_CTR];

	hpc_dec_if dec ();

	// selector 0 and out-of-range codes count nothing
	function automatic logic evt_hit(input logic [CNT_W-1:0] s, input logic [NUM_EVT_IN-1:0] ev);
		logic hit;
		hit = 1'b0;
		for (int k = 0; k < NUM_EVT_IN; k++) begin
			if (s == CNT_W'(k + 1)) begin
				hit = ev[k];
			end
		end
		return hit;
	endfunction : evt_hit

	// ------------------------------------------------------------
	// access decode and privilege check
	// ------------------------------------------------------------
	assign dec.addr = csr_addr_i;
	assign dec.priv = csr_priv_i;
	assign dec.mask = st.acc_mask;
	assign dec.we = csr_we_i;

	hpc_csr_dec #(
		.HAS_UMODE (HAS_UMODE),
		.HAS_SMODE (HAS_SMODE),
		.HAS_OVF   (HAS_OVF)
	) u_dec (
		.bus (dec.dec)
	);

	// the request is made at commit, so the write lands at this edge and
	// replaces the increment the writing instruction itself would cause
	assign wr_ok = csr_req_i && csr_we_i && !dec.illegal;

	// ------------------------------------------------------------
	// counter slices
	// ------------------------------------------------------------
	for (genvar i = 0; i < NUM_CTR; i++) begin : g_ctr
		if (i == IDX_TIME) begin : g_none
			assign slice_nxt[i] = '0;
		end else begin : g_slice
			localparam bit IMPL = (i < FIRST_EVT) ? 1'b1 : EVT_IMPL[i];
			localparam int W = (i < FIRST_EVT) ? CNT_W : CTR_WIDTH;
			logic own_lo;
			logic own_hi;
			logic own_any;
			logic peer_lo;
			logic peer_hi;
			hpc_slice_if sl ();

			assign own_lo = wr_ok && dec.view == VIEW_M_LO && dec.idx == 5'(i);
			assign own_hi = wr_ok && dec.view == VIEW_M_HI && dec.idx == 5'(i);
			assign own_any = own_lo || own_hi;
			// a sharing hart's write to the cycle counter lands here too; an own
			// write of the same cycle takes the whole counter, so data never mixes
			assign peer_lo = (i == IDX_CYCLE) && CYCLE_SHARED && !own_any
				&& peer_share_we_i[SHARE_CYC_LO];
			assign peer_hi = (i == IDX_CYCLE) && CYCLE_SHARED && !own_any
				&& peer_share_we_i[SHARE_CYC_HI];
			assign sl.we_lo = own_lo || peer_lo;
			assign sl.we_hi = own_hi || peer_hi;
			assign sl.wdata = own_any ? csr_wdata_i : peer_share_wdata_i;
			assign sl.cur = st.cnt[i];
			assign sl.inh = st.inhibit[i];
			if (i == IDX_CYCLE) begin : g_cyc
				assign sl.inc = 1'b1;
			end else if (i == IDX_RETIRE) begin : g_ret
				assign sl.inc = retire_i;
			end else begin : g_evt
				assign sl.inc = evt_hit(st.sel[i], event_i);
			end

			hpc_cnt_slice #(
				.W    (W),
				.IMPL (IMPL)
			) u_slice (
				.bus (sl.slice)
			);

			assign slice_nxt[i] = sl.nxt;
		end
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		next_st = st;
		next_st.ack = csr_req_i;
		next_st.illegal = csr_req_i && dec.illegal;
		next_st.rdata = '0;
		next_st.share_we = '0;
		next_st.share_wd = csr_wdata_i;
		// counters keep counting whatever the mask or a read does; a write to a counter replaces its increment
		for (int i = 0; i < NUM_CTR; i++) begin
			next_st.cnt[i] = slice_nxt[i];
		end

		if (csr_req_i && !dec.illegal) begin
			unique case (dec.view)
				VIEW_M_LO: begin
					next_st.rdata = st.cnt[dec.idx][XLEN-1:0];
				end
				VIEW_M_HI: begin
					next_st.rdata = st.cnt[dec.idx][CNT_W-1:XLEN];
				end
				VIEW_U_LO: begin
					next_st.rdata = (dec.idx == IDX_TIME) ? wallclock_i[XLEN-1:0]
						: st.cnt[dec.idx][XLEN-1:0];
				end
				VIEW_U_HI: begin
					next_st.rdata = (dec.idx == IDX_TIME) ? wallclock_i[CNT_W-1:XLEN]
						: st.cnt[dec.idx][CNT_W-1:XLEN];
				end
				VIEW_SEL_LO: begin
					next_st.rdata = st.sel[dec.idx][XLEN-1:0];
				end
				VIEW_SEL_HI: begin
					next_st.rdata = st.sel[dec.idx][CNT_W-1:XLEN];
				end
				VIEW_CTRL: begin
					next_st.rdata = (dec.idx == IDX_CTRL_MASK) ? st.acc_mask : st.inhibit;
				end
				default: begin
					next_st.rdata = '0;
				end
			endcase
		end

		if (CYCLE_SHARED && peer_share_we_i[SHARE_CY_INH]) begin
			next_st.inhibit[IDX_CYCLE] = peer_share_wdata_i[IDX_CYCLE];
		end

		if (wr_ok) begin
			unique case (dec.view)
				VIEW_SEL_LO: begin
					if (EVT_IMPL[dec.idx]) begin
						next_st.sel[dec.idx][XLEN-1:0] = csr_wdata_i;
					end
				end
				VIEW_SEL_HI: begin
					if (EVT_IMPL[dec.idx]) begin
						next_st.sel[dec.idx][CNT_W-1:XLEN] = csr_wdata_i;
					end
				end
				VIEW_CTRL: begin
					if (dec.idx == IDX_CTRL_MASK) begin
						next_st.acc_mask = csr_wdata_i;
					end else begin
						next_st.inhibit = csr_wdata_i & INH_LEGAL;
						next_st.share_we[SHARE_CY_INH] = CYCLE_SHARED;
					end
				end
				VIEW_M_LO: begin
					next_st.share_we[SHARE_CYC_LO] = CYCLE_SHARED && dec.idx == IDX_CYCLE;
				end
				VIEW_M_HI: begin
					next_st.share_we[SHARE_CYC_HI] = CYCLE_SHARED && dec.idx == IDX_CYCLE;
				end
				default: begin
					next_st.rdata = next_st.rdata;
				end
			endcase
		end

		for (int i = 0; i < NUM_CTR; i++) begin
			next_st.sel[i] = next_st.sel[i] & SEL_MASK;
			if (i < FIRST_EVT || !EVT_IMPL[i]) begin
				next_st.sel[i] = '0;
			end
		end
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	// counters are left out of reset on purpose: they start arbitrary
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			st.acc_mask <= '0;
			st.inhibit <= '0;
			st.sel <= '0;
			st.rdata <= '0;
			st.illegal <= 1'b0;
			st.ack <= 1'b0;
			st.share_we <= '0;
			st.share_wd <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign csr_ack_o = st.ack;
	assign csr_rdata_o = st.rdata;
	assign csr_illegal_o = st.illegal;
	assign share_we_o = st.share_we;
	assign share_wdata_o = st.share_wd;

endmodule : hpc_perf_counter_unit

`default_nettype wire

/* File: logic/hpc_pkg.sv */
package hpc_pkg;

	localparam int XLEN      = 32;
	localparam int CNT_W     = 64;
	localparam int NUM_CTR   = 32;
	localparam int FIRST_EVT = 3;
	localparam int CSR_AW    = 8;
	localparam int VIEW_LSB  = 5;

	// ------------------------------------------------------------
	// address map: view in the upper bits, counter index below
	// ------------------------------------------------------------
	localparam logic [2:0] VIEW_M_LO   = 3'h0;
	localparam logic [2:0] VIEW_M_HI   = 3'h1;
	localparam logic [2:0] VIEW_SEL_LO = 3'h2;
	localparam logic [2:0] VIEW_SEL_HI = 3'h3;
	localparam logic [2:0] VIEW_U_LO   = 3'h4;
	localparam logic [2:0] VIEW_U_HI   = 3'h5;
	localparam logic [2:0] VIEW_CTRL   = 3'h6;

	localparam logic [4:0] IDX_CYCLE     = 5'h00;
	localparam logic [4:0] IDX_TIME      = 5'h01;
	localparam logic [4:0] IDX_RETIRE    = 5'h02;
	localparam logic [4:0] IDX_FIRST_EVT = 5'h03;
	localparam logic [4:0] IDX_CTRL_MASK = 5'h00;
	localparam logic [4:0] IDX_CTRL_INH  = 5'h01;

	localparam logic [1:0] PRIV_U = 2'h0;
	localparam logic [1:0] PRIV_S = 2'h1;
	localparam logic [1:0] PRIV_M = 2'h3;

	localparam logic [31:0] CORE_CTR_BITS = 32'h0000_0005;
	localparam logic [31:0] TIME_BIT      = 32'h0000_0002;

	localparam int SHARE_W      = 3;
	localparam int SHARE_CYC_LO = 0;
	localparam int SHARE_CYC_HI = 1;
	localparam int SHARE_CY_INH = 2;

	localparam logic [CNT_W-1:0] CNT_ONE = 64'h0000_0000_0000_0001;

	typedef struct packed {
		logic [XLEN-1:0]                 acc_mask;
		logic [XLEN-1:0]                 inhibit;
		logic [NUM_CTR-1:0][CNT_W-1:0]   cnt;
		logic [NUM_CTR-1:0][CNT_W-1:0]   sel;
		logic [XLEN-1:0]                 rdata;
		logic                            illegal;
		logic                            ack;
		logic [SHARE_W-1:0]              share_we;
		logic [XLEN-1:0]                 share_wd;
	} hpc_state_t;

endpackage : hpc_pkg

/* File: tb/hpc_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module hpc_chk
	import hpc_pkg::*;
#(
	parameter bit CYCLE_SHARED = 1'b0
) (
	input wire logic               clock_i,
	input wire logic               sys_rst_i,
	input wire logic               csr_req_i,
	input wire logic               csr_we_i,
	input wire logic [CSR_AW-1:0]  csr_addr_i,
	input wire logic [XLEN-1:0]    csr_wdata_i,
	input wire logic [1:0]         csr_priv_i,
	input wire logic [CNT_W-1:0]   wallclock_i,
	input wire logic               csr_ack_o,
	input wire logic [XLEN-1:0]    csr_rdata_o,
	input wire logic               csr_illegal_o,
	input wire logic [SHARE_W-1:0] share_we_o,
	input wire logic [XLEN-1:0]    share_wdata_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);

	wire logic       rd_req = csr_req_i && !csr_we_i;
	wire logic       wr_m   = csr_req_i && csr_we_i && csr_priv_i == PRIV_M;
	wire logic [2:0] view   = csr_addr_i[7:5];
	wire logic [4:0] idx    = csr_addr_i[4:0];
	wire logic       low_v  = view == VIEW_U_LO || view == VIEW_U_HI;
	// shadow of the access mask, so lower-mode legality can be judged from the ports
	logic [XLEN-1:0] mask_seen;
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			mask_seen <= '0;
		end else if (wr_m && csr_addr_i == {VIEW_CTRL, IDX_CTRL_MASK}) begin
			mask_seen <= csr_wdata_i;
		end
	end

	ack_follows_req_a: assert property (csr_req_i |=> csr_ack_o)
		else $error("no answer one cycle after a request");
	idle_quiet_a: assert property (!csr_req_i |=> !csr_ack_o && share_we_o == '0)
		else $error("answer or share pulse without a request");
	refused_zero_a: assert property (csr_illegal_o |-> csr_ack_o && csr_rdata_o == '0)
		else $error("refused access returned data");
	hidden_read_trap_a: assert property (
		rd_req && csr_priv_i == PRIV_S && low_v && !mask_seen[idx] |=> csr_illegal_o)
		else $error("hidden counter read from lower mode not refused");
	shown_read_ok_a: assert property (
		rd_req && csr_priv_i == PRIV_S && low_v && mask_seen[idx] |=> !csr_illegal_o)
		else $error("enabled counter read from lower mode refused");
	view_read_only_a: assert property (csr_req_i && csr_we_i && low_v |=> csr_illegal_o)
		else $error("write to lower-mode view accepted");
	wallclock_lo_a: assert property (rd_req && csr_addr_i == {VIEW_U_LO, IDX_TIME}
		|=> csr_illegal_o || csr_rdata_o == 32'($past(wallclock_i)))
		else $error("wall-clock low view differs from timer");
	wallclock_hi_a: assert property (rd_req && csr_addr_i == {VIEW_U_HI, IDX_TIME}
		|=> csr_illegal_o || csr_rdata_o == 32'($past(wallclock_i) >> 32))
		else $error("wall-clock high view differs from timer");
	time_uninhib_a: assert property (
		rd_req && csr_addr_i == {VIEW_CTRL, IDX_CTRL_INH} |=> csr_illegal_o || !csr_rdata_o[1])
		else $error("inhibit bit 1 read as one");
	share_pulse_a: assert property (wr_m && csr_addr_i == {VIEW_M_LO, IDX_CYCLE}
		|=> !CYCLE_SHARED || (share_we_o == 3'h1 && share_wdata_o == $past(csr_wdata_i)))
		else $error("cycle write not passed to sharing harts");
	share_inh_a: assert property (wr_m && csr_addr_i == {VIEW_CTRL, IDX_CTRL_INH}
		|=> !CYCLE_SHARED || share_we_o[SHARE_CY_INH])
		else $error("inhibit write not passed to sharing harts");
endmodule : hpc_chk

bind hpc_perf_counter_unit hpc_chk #(.CYCLE_SHARED(CYCLE_SHARED)) chk (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .csr_req_i(csr_req_i), .csr_we_i(csr_we_i),
	.csr_addr_i(csr_addr_i), .csr_wdata_i(csr_wdata_i), .csr_priv_i(csr_priv_i),
	.wallclock_i(wallclock_i), .csr_ack_o(csr_ack_o), .csr_rdata_o(csr_rdata_o),
	.csr_illegal_o(csr_illegal_o), .share_we_o(share_we_o), .share_wdata_o(share_wdata_o));

`default_nettype wire

/* File: tb/hpc_peer_hart.sv */
`timescale 1ns/1ps
`default_nettype none

// sharing hart: pulses its cycle and inhibit writes for one cycle
module hpc_peer_hart
	import hpc_pkg::*;
(
	input  wire logic          clock_i,
	output logic [SHARE_W-1:0] share_we_o,
	output logic [XLEN-1:0]    share_wdata_o
);
	initial begin
		share_we_o = '0;
		share_wdata_o = 32'h5a5a_a5a5;
	end
	task automatic send(input logic [SHARE_W-1:0] we, input logic [XLEN-1:0] d);
		@(negedge clock_i);
		share_we_o = we;
		share_wdata_o = d;
		@(negedge clock_i);
		share_we_o = '0;
		// stale data is inverted so a late sample cannot pass by luck
		share_wdata_o = ~d;
	endtask : send
endmodule : hpc_peer_hart

`default_nettype wire

/* File: tb/testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import hpc_pkg::*;
	localparam logic [7:0] A_CYC  = {VIEW_M_LO, IDX_CYCLE};
	localparam logic [7:0] A_CYCH = {VIEW_M_HI, IDX_CYCLE};
	localparam logic [7:0] A_RET  = {VIEW_M_LO, IDX_RETIRE};
	localparam logic [7:0] A_RETH = {VIEW_M_HI, IDX_RETIRE};
	localparam logic [7:0] A_MASK = {VIEW_CTRL, IDX_CTRL_MASK};
	localparam logic [7:0] A_INH  = {VIEW_CTRL, IDX_CTRL_INH};
	localparam logic [7:0] A_SEL3 = {VIEW_SEL_LO, IDX_FIRST_EVT};
	localparam logic [7:0] A_E3   = {VIEW_M_LO, IDX_FIRST_EVT};
	localparam logic [7:0] A_E3H  = {VIEW_M_HI, IDX_FIRST_EVT};
	localparam logic [1:0] M      = PRIV_M;
	logic               clock_i, sys_rst_i, csr_req_i, csr_we_i, retire_i;
	logic               csr_ack_o, csr_illegal_o;
	logic [CSR_AW-1:0]  csr_addr_i;
	logic [XLEN-1:0]    csr_wdata_i, csr_rdata_o, share_wdata_o, peer_wdata;
	logic [1:0]         csr_priv_i;
	logic [15:0]        event_i;
	logic [CNT_W-1:0]   wallclock_i;
	logic [SHARE_W-1:0] peer_we, share_we_o;
	int                 mismatches, total_checks;

	hpc_perf_counter_unit #(.CYCLE_SHARED(1'b1)) dut (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .csr_req_i(csr_req_i),
		.csr_we_i(csr_we_i), .csr_addr_i(csr_addr_i), .csr_wdata_i(csr_wdata_i),
		.csr_priv_i(csr_priv_i), .retire_i(retire_i), .event_i(event_i),
		.wallclock_i(wallclock_i), .peer_share_we_i(peer_we), .peer_share_wdata_i(peer_wdata),
		.csr_ack_o(csr_ack_o), .csr_rdata_o(csr_rdata_o), .csr_illegal_o(csr_illegal_o),
		.share_we_o(share_we_o), .share_wdata_o(share_wdata_o));
	hpc_peer_hart peer (.clock_i(clock_i), .share_we_o(peer_we), .share_wdata_o(peer_wdata));

	initial begin
		clock_i = 1'b0;
		forever #50 clock_i = ~clock_i;
	end

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// one access: request for one cycle, answer sampled at the next falling edge
	task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d,
			input logic [1:0] p, input logic [31:0] e, input logic ei);
		@(negedge clock_i);
		csr_req_i = 1'b1;
		csr_we_i = we;
		csr_addr_i = a;
		csr_wdata_i = d;
		csr_priv_i = p;
		@(negedge clock_i);
		csr_req_i = 1'b0;
		chk($sformatf("ack@%h", a), 32'h1, {31'h0, csr_ack_o});
		chk($sformatf("illegal@%h", a), {31'h0, ei}, {31'h0, csr_illegal_o});
		if (!we) chk($sformatf("rdata@%h", a), e, csr_rdata_o);
	endtask : acc

	task automatic burst(input int n, input logic [15:0] ev, input logic r);
		@(negedge clock_i);
		event_i = ev;
		retire_i = r;
		repeat (n) @(negedge clock_i);
		event_i = '0;
		retire_i = 1'b0;
	endtask : burst

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : end_of_test

	initial begin
		repeat (5000) @(posedge clock_i);
		mismatches++;
		$display("MISMATCH run length expected done seen hang");
		end_of_test();
	end

	initial begin
		{sys_rst_i, csr_req_i, csr_we_i, retire_i} = 4'h8;
		{csr_addr_i, csr_wdata_i, csr_priv_i, event_i} = '0;
		wallclock_i = 64'h0123_4567_89ab_cdef;
		repeat (12) @(negedge clock_i);
		sys_rst_i = 1'b0;
		acc(0, A_MASK, 0, M, 32'h0, 0);
		acc(0, A_INH, 0, M, 32'h0, 0);
		acc(0, A_SEL3, 0, M, 32'h0, 0);
		acc(1, A_INH, 32'hffff_ffff, M, 0, 0);
		acc(0, A_INH, 0, M, 32'hffff_fffd, 0);
		// counters start unknown and one unknown bit spoils every later sum:
		// load both halves while everything is inhibited
		acc(1, A_CYCH, 0, M, 0, 0);
		acc(1, A_CYC, 0, M, 0, 0);
		acc(1, A_RETH, 0, M, 0, 0);
		acc(1, A_RET, 0, M, 0, 0);
		acc(1, A_E3H, 0, M, 0, 0);
		acc(1, A_E3, 0, M, 0, 0);
		acc(0, A_CYC, 0, M, 32'h0, 0);
		acc(1, A_INH, 0, M, 0, 0);
		$display("test reset_and_inhibit done");
		acc(1, A_CYCH, 0, M, 0, 0);
		acc(1, A_CYC, 32'h10, M, 0, 0);
		chk("share_we", 32'h1, {29'h0, share_we_o});
		chk("share_wdata", 32'h10, share_wdata_o);
		acc(0, A_CYC, 0, M, 32'h11, 0);
		acc(0, A_CYC, 0, M, 32'h13, 0);
		acc(1, A_CYCH, 32'h1, M, 0, 0);
		acc(1, A_CYC, 32'hffff_ffff, M, 0, 0);
		acc(0, A_CYCH, 0, M, 32'h2, 0);
		acc(0, A_CYC, 0, M, 32'h2, 0);
		acc(1, A_INH, 32'h1, M, 0, 0);
		acc(1, A_CYC, 32'h5, M, 0, 0);
		acc(0, A_CYC, 0, M, 32'h5, 0);
		acc(0, A_CYC, 0, M, 32'h5, 0);
		acc(1, A_INH, 0, M, 0, 0);
		$display("test cycle_counter done");
		acc(1, A_RET, 32'h100, M, 0, 0);
		burst(7, 16'h0, 1'b1);
		acc(0, A_RET, 0, M, 32'h107, 0);
		acc(1, A_INH, 32'h4, M, 0, 0);
		burst(3, 16'h0, 1'b1);
		acc(0, A_RET, 0, M, 32'h107, 0);
		acc(1, A_INH, 0, M, 0, 0);
		$display("test retired_counter done");
		acc(1, A_SEL3, 32'h102, M, 0, 0);
		acc(0, A_SEL3, 0, M, 32'h2, 0);
		acc(1, A_E3, 0, M, 0, 0);
		burst(5, 16'h3, 1'b0);
		acc(0, A_E3, 0, M, 32'h5, 0);
		acc(1, A_SEL3, 0, M, 0, 0);
		burst(3, 16'hffff, 1'b0);
		acc(0, A_E3, 0, M, 32'h5, 0);
		acc(1, A_E3H, 32'habc, M, 0, 0);
		acc(0, A_E3H, 0, M, 32'habc, 0);
		acc(0, {VIEW_SEL_HI, IDX_FIRST_EVT}, 0, M, 0, 1);
		acc(0, {VIEW_SEL_LO, IDX_RETIRE}, 0, M, 0, 1);
		$display("test event_counter done");
		wallclock_i = 64'hfedc_ba98_7654_3210;
		acc(0, {VIEW_U_LO, IDX_CYCLE}, 0, PRIV_S, 0, 1);
		acc(1, A_MASK, 32'h7, M, 0, 0);
		acc(0, A_MASK, 0, M, 32'h7, 0);
		acc(0, {VIEW_U_LO, IDX_RETIRE}, 0, PRIV_S, 32'h107, 0);
		acc(0, {VIEW_U_HI, IDX_TIME}, 0, PRIV_S, 32'hfedc_ba98, 0);
		acc(0, {VIEW_U_LO, IDX_TIME}, 0, PRIV_S, 32'h7654_3210, 0);
		acc(0, {VIEW_U_LO, IDX_FIRST_EVT}, 0, PRIV_S, 0, 1);
		acc(0, {VIEW_U_LO, IDX_CYCLE}, 0, PRIV_U, 0, 1);
		acc(1, {VIEW_U_LO, IDX_CYCLE}, 32'h1, M, 0, 1);
		$display("test lower_mode_access done");
		peer.send(3'h1, 32'h200);
		acc(0, A_CYC, 0, M, 32'h201, 0);
		peer.send(3'h4, 32'h1);
		acc(0, A_INH, 0, M, 32'h1, 0);
		$display("test shared_cycle done");
		end_of_test();
	end
endmodule : testbench

`default_nettype wire
